// *** dv/spr_disp_model.sv ***
// Display bus partner: puts one pressure word on the bus per request.
// Assumes the bench raises send for one pclk cycle per word.
`timescale 1ns/1ps
`default_nettype none
module spr_disp_model (
   input wire logic pclk,
   input wire logic send,
   input wire logic [6:0] mant,
   input wire logic [4:0] expo,
   output logic disp_valid,
   output logic [6:0] disp_mant,
   output logic [4:0] disp_exp
);
   // Word for one cycle, then flipped lines so stale data never looks valid
   always_ff @(posedge pclk) begin
      disp_valid <= send;
      if (send) begin
         disp_mant <= mant;
         disp_exp <= expo;
      end else begin
         disp_mant <= ~disp_mant;
         disp_exp <= ~disp_exp;
      end
   end
endmodule // spr_disp_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the setpoint relay controller.
// Assumes short panel timing parameters and the display bus model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, disp_valid;
   logic [6:0] disp_mant, shown_mant, nv_mant, s_mant = 7'h00;
   logic [4:0] disp_exp, shown_exp, nv_exp, s_exp = 5'h00;
   logic send = 1'b0, btn_raise = 1'b0, btn_lower = 1'b0, chan_sel = 1'b0;
   logic [1:0] ovr_right = 2'h0, ovr_left = 2'h0, polarity_sw = 2'h0;
   logic [1:0] dis_one = 2'h0, dis_two = 2'h0, led_status;
   logic ionization_sensor = 1'b1, degas_active = 1'b0;
   logic relay_channel_one, relay_channel_two, show_setpoint, nv_write, nv_chan;
   int mismatches = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;

   // 20 MHz clock
   always #25 pclk = ~pclk;

   // Short counts keep the panel walk fast
   spr_relay_ctrl #(.HOLD_CYC(40), .SLOW_CYC(8), .FAST_CYC(2)) i_spr_relay_ctrl (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .disp_valid(disp_valid), .disp_mant(disp_mant),
      .disp_exp(disp_exp), .btn_raise(btn_raise), .btn_lower(btn_lower),
      .chan_sel(chan_sel), .ovr_right(ovr_right), .ovr_left(ovr_left),
      .polarity_sw(polarity_sw), .channel_one_disable_pair(dis_one),
      .channel_two_disable_pair(dis_two), .ionization_sensor(ionization_sensor),
      .degas_active(degas_active), .relay_channel_one(relay_channel_one),
      .relay_channel_two(relay_channel_two), .led_status(led_status),
      .show_setpoint(show_setpoint), .shown_mant(shown_mant), .shown_exp(shown_exp),
      .nv_write(nv_write), .nv_chan(nv_chan), .nv_mant(nv_mant), .nv_exp(nv_exp));

   spr_disp_model i_spr_disp_model (.pclk(pclk), .send(send), .mant(s_mant),
      .expo(s_exp), .disp_valid(disp_valid), .disp_mant(disp_mant),
      .disp_exp(disp_exp));

   // Verdict and end of run
   task automatic results;
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Count a comparison, report a miss
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; waits for pready, then an idle cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(pready === 1'b1, "no pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Send a pressure word and let the relays settle
   task automatic press(input logic [6:0] m, input logic [4:0] e);
      s_mant <= m;
      s_exp <= e;
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      w(6);
   endtask

   // Relays and LEDs must agree with the expected pair
   task automatic rel(input logic [1:0] x);
      chk({relay_channel_two, relay_channel_one} === x && led_status === x, "relay");
   endtask

   // Hold a button n cycles, then wait for the store pulse
   task automatic hold(input logic up, input int n);
      int k;
      if (up) btn_raise <= 1'b1;
      else btn_lower <= 1'b1;
      w(n);
      btn_raise <= 1'b0;
      btn_lower <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (nv_write !== 1'b1 && k < 80);
      chk(nv_write === 1'b1, "no store");
      @(posedge pclk);
      chk(show_setpoint === 1'b0, "display kept");
   endtask

   task automatic t_regs;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd === 32'h0000_0a0a && er === 1'b0, "sp reset");
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(er === 1'b1, "unmapped");
      apb(1'b1, 8'h00, 32'h0000_0a09);
      chk(er === 1'b1, "low mant");
      apb(1'b1, 8'h00, 32'h0000_155b);
      chk(er === 1'b1, "over top");
      apb(1'b1, 8'h00, 32'h0000_155a);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd === 32'h0000_155a && er === 1'b0, "top value");
   endtask

   task automatic t_hyst;
      apb(1'b1, 8'h00, 32'h0000_0a3f);
      press(7'h3f, 5'h0a);
      rel(2'b00);
      press(7'h3e, 5'h0a);
      rel(2'b01);
      press(7'h45, 5'h0a);
      rel(2'b01);
      press(7'h46, 5'h0a);
      rel(2'b00);
      apb(1'b1, 8'h00, 32'h0000_0a42);
      press(7'h41, 5'h0a);
      rel(2'b01);
      press(7'h49, 5'h0a);
      rel(2'b01);
      press(7'h4a, 5'h0a);
      rel(2'b00);
   endtask

   task automatic t_above;
      polarity_sw <= 2'b10;
      apb(1'b1, 8'h04, 32'h0000_0a3f);
      press(7'h40, 5'h0a);
      rel(2'b11);
      press(7'h39, 5'h0a);
      rel(2'b11);
      press(7'h38, 5'h0a);
      rel(2'b01);
   endtask

   // Overrides, disable pair and gauge off, from relays at 01
   task automatic t_force;
      ovr_right <= 2'b10;
      w(5);
      rel(2'b11);
      ovr_right <= 2'b00;
      ovr_left <= 2'b01;
      w(5);
      rel(2'b00);
      ovr_left <= 2'b00;
      dis_one <= 2'b11;
      w(5);
      rel(2'b00);
      dis_one <= 2'b01;
      w(5);
      rel(2'b01);
      dis_one <= 2'b00;
      ovr_right <= 2'b11;
      ionization_sensor <= 1'b0;
      w(5);
      rel(2'b00);
      ovr_right <= 2'b00;
      ionization_sensor <= 1'b1;
      w(5);
      rel(2'b01);
   endtask

   task automatic t_degas;
      degas_active <= 1'b1;
      w(5);
      press(7'h63, 5'h0c);
      rel(2'b01);
      degas_active <= 1'b0;
      w(5);
      rel(2'b01);
      press(7'h63, 5'h0c);
      rel(2'b10);
      press(7'h38, 5'h0a);
      rel(2'b01);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk(rd === 32'h0000_0538 && er === 1'b0, "pressure reg");
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(rd === 32'h0000_0085 && er === 1'b0, "status reg");
   endtask

   // Panel: raise ch1, lower ch2, then a decade crossing
   task automatic t_panel;
      btn_raise <= 1'b1;
      w(5);
      chk(shown_exp === 5'h0a, "shown exp");
      chk(show_setpoint === 1'b1 && shown_mant === 7'h42, "show");
      press(7'h63, 5'h0c);
      rel(2'b01);
      hold(1'b1, 1);
      chk(nv_chan === 1'b0 && nv_mant === 7'h43 && nv_exp === 5'h0a, "raise");
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd === 32'h0000_0a43, "sp kept");
      chan_sel <= 1'b1;
      w(4);
      hold(1'b0, 12);
      chk(nv_chan === 1'b1 && nv_mant === 7'h3e, "lower");
      chan_sel <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_0a62);
      hold(1'b1, 27);
      chk(nv_exp === 5'h0b && nv_mant >= 7'h0d, "fast scroll");
   endtask

   // Hang guard, far beyond the expected run length
   initial begin
      w(20000);
      mismatches++;
      results();
   end

   // Main sequence
   initial begin
      w(6);
      presetn <= 1'b1;
      w(3);
      t_regs();
      t_hyst();
      t_above();
      t_force();
      t_degas();
      t_panel();
      results();
   end
endmodule // testbench
`default_nettype wire

// *** logic/spr_pkg.sv ***
// Constants and types for the two-channel setpoint relay controller.
// Assumes a 20 MHz pclk and a display bus in the pclk domain.
// Behaviour
// RULE1 - Status LEDs always show actual relay states
// RULE2 - Button tap shows selected setpoint two seconds
// RULE3 - Held raise/lower button scrolls the setpoint
// RULE4 - Scroll slow, faster after crossing a decade
// RULE5 - Two seconds after release: pressure, store
// RULE6 - Ion gauge off releases both relays
// RULE7 - Polarity switch selects below or above activation
// RULE8 - Disable switch holds relay permanently off
// RULE9 - Setpoint two-digit mantissa, 1e-12 to 9e5
// RULE10 - Setpoints compared raw, unit change ignored
// RULE11 - Degas freezes relay evaluation pressure
// RULE12 - Below: on under setpoint, off past hysteresis
// RULE13 - Hysteresis is 10 percent, rounded half up
// RULE14 - Shown setpoint never taken as pressure
// RULE15 - Override right forces on, left off
// RULE16 - Working setpoint copies kept in internal RAM
// RULE17 - Above polarity mirrors the hysteresis band
// RULE18 - Re-evaluate on each new pressure value
`default_nettype none
package spr_pkg;
   // Clock and panel timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned HOLD_MS = 2000;
   localparam int unsigned SLOW_MS = 400;
   localparam int unsigned FAST_MS = 100;
   localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
   localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
   localparam int unsigned FAST_CYC = CLK_HZ / 1000 * FAST_MS;
   localparam int CNT_W = 26;
   // Value format: biased exponent above a 10..99 mantissa
   localparam int MANT_W = 7;
   localparam int EXP_W = 5;
   localparam int KEY_W = 12;
   localparam logic [6:0] MANT_MIN = 7'h0a;
   localparam logic [6:0] MANT_MAX = 7'h63;
   localparam logic [6:0] MANT_TOP = 7'h5a;
   localparam logic [4:0] EXP_MIN = 5'h04;
   localparam logic [4:0] EXP_MAX = 5'h15;
   localparam logic [6:0] RST_MANT = 7'h0a;
   localparam logic [4:0] RST_EXP = 5'h0a;
   // APB map and fields
   localparam logic [7:0] REG_SP0 = 8'h00;
   localparam logic [7:0] REG_SP1 = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_PRESS = 8'h0c;
   localparam int SP_EXP_LSB = 8;
   // Panel sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_HELD = 3'h2,
      ST_SHOW = 3'h4
   } spr_state_t;
endpackage
`default_nettype wire

// *** logic/spr_relay_ctrl.sv ***
// Two-channel setpoint relay controller with APB access to setpoints.
// Assumes panel switches are asynchronous and the display bus is on pclk.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spr_relay_ctrl #(
   parameter int unsigned HOLD_CYC = spr_pkg::HOLD_CYC,
   parameter int unsigned SLOW_CYC = spr_pkg::SLOW_CYC,
   parameter int unsigned FAST_CYC = spr_pkg::FAST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic disp_valid,
   input wire logic [6:0] disp_mant,
   input wire logic [4:0] disp_exp,
   input wire logic btn_raise,
   input wire logic btn_lower,
   input wire logic chan_sel,
   input wire logic [1:0] ovr_right,
   input wire logic [1:0] ovr_left,
   input wire logic [1:0] polarity_sw,
   input wire logic [1:0] channel_one_disable_pair,
   input wire logic [1:0] channel_two_disable_pair,
   input wire logic ionization_sensor,
   input wire logic degas_active,
   output logic relay_channel_one,
   output logic relay_channel_two,
   output logic [1:0] led_status,
   output logic show_setpoint,
   output logic [6:0] shown_mant,
   output logic [4:0] shown_exp,
   output logic nv_write,
   output logic nv_chan,
   output logic [6:0] nv_mant,
   output logic [4:0] nv_exp
);
   localparam int CW = spr_pkg::CNT_W;
   localparam int KW = spr_pkg::KEY_W;

   // Panel pins, two flops each before use
   logic [14:0] meta_r;
   logic [14:0] sync_r;
   logic raise_s, lower_s, chan_s, ig_s, degas_s, btn_s;
   logic [1:0] right_s, left_s, pol_s, dis_s;
   assign raise_s = sync_r[0];
   assign lower_s = sync_r[1];
   assign chan_s = sync_r[2];
   assign right_s = sync_r[4:3];
   assign left_s = sync_r[6:5];
   assign pol_s = sync_r[8:7];
   // A channel is off only with both switches of its pair on
   assign dis_s = {&sync_r[12:11], &sync_r[10:9]};
   assign ig_s = sync_r[13];
   assign degas_s = sync_r[14];
   assign btn_s = raise_s | lower_s;

   // Synchroniser chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 15'h0000;
         sync_r <= 15'h0000;
      end else begin
         meta_r <= {degas_active, ionization_sensor, channel_two_disable_pair,
                    channel_one_disable_pair, polarity_sw, ovr_left, ovr_right,
                    chan_sel, btn_lower, btn_raise};
         sync_r <= meta_r;
      end
   end

   // State registers and their next values
   spr_pkg::spr_state_t state_r, state_nxt;
   logic chan_r, chan_nxt;
   logic fast_r, fast_nxt;
   logic [CW-1:0] rate_r, rate_nxt;
   logic [CW-1:0] hold_r, hold_nxt;
   logic [6:0] sp_m_r [2];   // Working setpoint copies
   logic [6:0] sp_m_nxt [2];
   logic [4:0] sp_e_r [2];
   logic [4:0] sp_e_nxt [2];
   logic [KW-1:0] press_r, press_nxt;   // Last real pressure
   logic eval_r, eval_nxt;
   logic [1:0] act_r, act_nxt;   // Automatic decisions
   logic [1:0] rel_nxt;
   logic show_r, show_nxt;
   logic [6:0] shm_r, shm_nxt;
   logic [4:0] she_r, she_nxt;
   logic nvw_r, nvw_nxt;
   logic nvc_r, nvc_nxt;
   logic [6:0] nvm_r, nvm_nxt;
   logic [4:0] nve_r, nve_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic rel1_r, rel2_r;
   logic [1:0] led_r;

   // Fold a threshold back into the 10..99 mantissa range
   function automatic logic [KW-1:0] thr(input logic [7:0] t, input logic [4:0] e);
      logic [7:0] q;
      logic [7:0] p;
      q = t / 8'h0a;
      p = 8'(t * 8'h0a);
      if (t >= 8'h64) begin
         thr = {5'(e + 5'h01), q[6:0]};
      end else if (t < 8'h0a) begin
         thr = {5'(e - 5'h01), p[6:0]};
      end else begin
         thr = {e, t[6:0]};
      end
   endfunction

   // Accepted setpoint range check
   function automatic logic sp_ok(input logic [6:0] m, input logic [4:0] e);
      sp_ok = (m >= spr_pkg::MANT_MIN) && (m <= spr_pkg::MANT_MAX) &&
              (e >= spr_pkg::EXP_MIN) && (e <= spr_pkg::EXP_MAX) &&
              !((e == spr_pkg::EXP_MAX) && (m > spr_pkg::MANT_TOP));
   endfunction

   // Per channel hysteresis and relay selection
   logic [KW-1:0] sp_key [2];
   logic [KW-1:0] hi_key [2];
   logic [KW-1:0] lo_key [2];
   logic [7:0] hyst [2];
   for (genvar g = 0; g < 2; g++) begin : g_chan
      // Raw comparison: units never enter into it [RULE10]
      assign sp_key[g] = {sp_e_r[g], sp_m_r[g]};
      // Ten percent, one digit, half rounds up [RULE13]
      assign hyst[g] = 8'(({1'b0, sp_m_r[g]} + 8'h05) / 8'h0a);
      // Release point one count past setpoint plus band [RULE12]
      assign hi_key[g] = thr(8'({1'b0, sp_m_r[g]} + hyst[g] + 8'h01), sp_e_r[g]);
      // Mirrored band for above polarity [RULE17]
      assign lo_key[g] = thr(8'({1'b0, sp_m_r[g]} - hyst[g] - 8'h01), sp_e_r[g]);
      // Decision only moves on a fresh pressure sample [RULE18] [RULE7]
      assign act_nxt[g] = !eval_r ? act_r[g] :
         !pol_s[g] ? ((press_r < sp_key[g]) ? 1'b1 :
                      (press_r >= hi_key[g]) ? 1'b0 : act_r[g]) :
                     ((press_r > sp_key[g]) ? 1'b1 :
                      (press_r <= lo_key[g]) ? 1'b0 : act_r[g]);
      // Gauge off, then disable, then override, then automatic [RULE6] [RULE8] [RULE15]
      assign rel_nxt[g] = ig_s && !dis_s[g] &&
         ((right_s[g] && !left_s[g]) ? 1'b1 :
          (left_s[g] && !right_s[g]) ? 1'b0 : act_r[g]);
   end

   // Sequencer, setpoint RAM, pressure capture and APB slave
   always_comb begin
      logic [6:0] m;
      logic [4:0] e;
      logic [CW-1:0] per;
      logic setup;
      logic wr_ok;
      m = sp_m_r[chan_r];
      e = sp_e_r[chan_r];
      per = fast_r ? CW'(FAST_CYC) : CW'(SLOW_CYC);
      setup = psel && !penable;
      wr_ok = sp_ok(pwdata[6:0], pwdata[12:8]);
      state_nxt = state_r;
      chan_nxt = chan_r;
      fast_nxt = fast_r;
      rate_nxt = rate_r;
      hold_nxt = hold_r;
      sp_m_nxt = sp_m_r;
      sp_e_nxt = sp_e_r;
      show_nxt = show_r;
      nvw_nxt = 1'b0;
      nvc_nxt = nvc_r;
      nvm_nxt = nvm_r;
      nve_nxt = nve_r;
      press_nxt = press_r;
      eval_nxt = 1'b0;
      // Only real pressure while no setpoint is shown, none in degas [RULE14] [RULE11]
      if (disp_valid && !show_r && !degas_s) begin
         press_nxt = {disp_exp, disp_mant};
         eval_nxt = 1'b1;
      end
      // APB answers in the access cycle after setup
      pready_nxt = setup;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (setup) begin
         if (paddr == spr_pkg::REG_SP0 || paddr == spr_pkg::REG_SP1) begin
            pslverr_nxt = pwrite && !wr_ok;
            if (!pwrite) begin
               prdata_nxt = {19'h0_0000, sp_e_r[paddr[2]], 1'b0, sp_m_r[paddr[2]]};
            end
         end else if (paddr == spr_pkg::REG_STAT) begin
            prdata_nxt = {24'h00_0000, ig_s, degas_s, chan_r, show_r, act_r,
                          rel2_r, rel1_r};
         end else if (paddr == spr_pkg::REG_PRESS) begin
            prdata_nxt = {20'h0_0000, press_r};
         end else begin
            pslverr_nxt = 1'b1;
         end
      end
      // Write takes effect at the completing edge; a scroll step overrides it
      if (psel && penable && pready_r && pwrite && !pslverr_r &&
          (paddr == spr_pkg::REG_SP0 || paddr == spr_pkg::REG_SP1)) begin
         sp_m_nxt[paddr[2]] = pwdata[6:0];
         sp_e_nxt[paddr[2]] = pwdata[12:8];
      end
      case (state_r)
         spr_pkg::ST_IDLE: begin
            // Any press brings up the selected setpoint [RULE2]
            if (btn_s) begin
               state_nxt = spr_pkg::ST_HELD;
               chan_nxt = chan_s;
               fast_nxt = 1'b0;
               rate_nxt = '0;
               show_nxt = 1'b1;
            end
         end
         spr_pkg::ST_HELD: begin
            if (!btn_s) begin
               state_nxt = spr_pkg::ST_SHOW;
               hold_nxt = '0;
            end else if (rate_r == CW'(per - CW'(1))) begin
               rate_nxt = '0;
               // One step per period, clamped to the legal range [RULE3] [RULE9]
               if (raise_s) begin
                  if (e == spr_pkg::EXP_MAX && m >= spr_pkg::MANT_TOP) begin
                     m = spr_pkg::MANT_TOP;
                  end else if (m == spr_pkg::MANT_MAX) begin
                     m = spr_pkg::MANT_MIN;
                     e = 5'(e + 5'h01);
                     fast_nxt = 1'b1;   // Decade crossed [RULE4]
                  end else begin
                     m = 7'(m + 7'h01);
                  end
               end else begin
                  if (e == spr_pkg::EXP_MIN && m == spr_pkg::MANT_MIN) begin
                     m = spr_pkg::MANT_MIN;
                  end else if (m == spr_pkg::MANT_MIN) begin
                     m = spr_pkg::MANT_MAX;
                     e = 5'(e - 5'h01);
                     fast_nxt = 1'b1;   // Decade crossed [RULE4]
                  end else begin
                     m = 7'(m - 7'h01);
                  end
               end
               // Working copy in RAM feeds compare and display [RULE16]
               sp_m_nxt[chan_r] = m;
               sp_e_nxt[chan_r] = e;
            end else begin
               rate_nxt = CW'(rate_r + CW'(1));
            end
         end
         spr_pkg::ST_SHOW: begin
            if (btn_s) begin
               // Every new hold starts slow again [RULE4]
               state_nxt = spr_pkg::ST_HELD;
               chan_nxt = chan_s;
               fast_nxt = 1'b0;
               rate_nxt = '0;
            end else if (hold_r == CW'(HOLD_CYC - 1)) begin
               // Back to pressure and commit to storage [RULE5]
               state_nxt = spr_pkg::ST_IDLE;
               show_nxt = 1'b0;
               nvw_nxt = 1'b1;
               nvc_nxt = chan_r;
               nvm_nxt = sp_m_r[chan_r];
               nve_nxt = sp_e_r[chan_r];
            end else begin
               hold_nxt = CW'(hold_r + CW'(1));
            end
         end
         default: begin
            state_nxt = spr_pkg::ST_IDLE;
         end
      endcase
      shm_nxt = sp_m_r[chan_r];
      she_nxt = sp_e_r[chan_r];
   end

   // Register everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= spr_pkg::ST_IDLE;
         chan_r <= 1'b0;
         fast_r <= 1'b0;
         rate_r <= '0;
         hold_r <= '0;
         sp_m_r <= '{spr_pkg::RST_MANT, spr_pkg::RST_MANT};
         sp_e_r <= '{spr_pkg::RST_EXP, spr_pkg::RST_EXP};
         press_r <= '0;
         eval_r <= 1'b0;
         act_r <= 2'h0;
         show_r <= 1'b0;
         shm_r <= 7'h00;
         she_r <= 5'h00;
         nvw_r <= 1'b0;
         nvc_r <= 1'b0;
         nvm_r <= 7'h00;
         nve_r <= 5'h00;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         rel1_r <= 1'b0;
         rel2_r <= 1'b0;
         led_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         chan_r <= chan_nxt;
         fast_r <= fast_nxt;
         rate_r <= rate_nxt;
         hold_r <= hold_nxt;
         sp_m_r <= sp_m_nxt;
         sp_e_r <= sp_e_nxt;
         press_r <= press_nxt;
         eval_r <= eval_nxt;
         act_r <= act_nxt;
         show_r <= show_nxt;
         shm_r <= shm_nxt;
         she_r <= she_nxt;
         nvw_r <= nvw_nxt;
         nvc_r <= nvc_nxt;
         nvm_r <= nvm_nxt;
         nve_r <= nve_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         rel1_r <= rel_nxt[0];
         rel2_r <= rel_nxt[1];
         led_r <= rel_nxt;   // LEDs mirror the driven relays [RULE1]
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign relay_channel_one = rel1_r;
   assign relay_channel_two = rel2_r;
   assign led_status = led_r;
   assign show_setpoint = show_r;
   assign shown_mant = shm_r;
   assign shown_exp = she_r;
   assign nv_write = nvw_r;
   assign nv_chan = nvc_r;
   assign nv_mant = nvm_r;
   assign nv_exp = nve_r;

   // Checks on the driven behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_led_relay_match: assert property (led_r == {rel2_r, rel1_r}) // [RULE1]
      else $error("LEDs differ from relays");
   chk_tap_shows_sp: assert property (btn_s && state_r == spr_pkg::ST_IDLE |=> show_r) // [RULE2]
      else $error("Press did not show setpoint");
   chk_commit_store: assert property ($fell(show_r) |-> nvw_r && nvc_r == $past(chan_r)) // [RULE5]
      else $error("Display end without store");
   chk_gauge_off_release: assert property (!ig_s |=> !rel1_r && !rel2_r) // [RULE6]
      else $error("Relay on with gauge off");
   chk_disable_off: assert property (dis_s[0] |=> !rel1_r) // [RULE8]
      else $error("Disabled relay active");
   chk_sp_in_range: assert property ( // [RULE9]
      sp_ok(sp_m_r[0], sp_e_r[0]) && sp_ok(sp_m_r[1], sp_e_r[1]))
      else $error("Setpoint out of range");
   chk_degas_freeze: assert property (degas_s |=> $stable(press_r) && !eval_r) // [RULE11]
      else $error("Pressure moved in degas");
   chk_below_activate: assert property ( // [RULE12]
      eval_r && !pol_s[0] && press_r < sp_key[0] |=> act_r[0])
      else $error("Below channel not active");
   chk_show_no_press: assert property (show_r |=> $stable(press_r)) // [RULE14]
      else $error("Setpoint taken as pressure");
   chk_override_on: assert property ( // [RULE15]
      ig_s && !dis_s[1] && right_s[1] && !left_s[1] |=> rel2_r)
      else $error("Override right ignored");
   chk_above_activate: assert property ( // [RULE17]
      eval_r && pol_s[1] && press_r > sp_key[1] |=> act_r[1])
      else $error("Above channel not active");
endmodule // spr_relay_ctrl
`default_nettype wire
